/* inc/sram_ctl_params.svh */
// Timing, width and pin-level constants for the asynchronous SRAM host controller.
// Assumes a 125 MHz controller clock and an 8192 x 9 common-I/O static RAM on the pins.
// Operation
// RULE_01: Write strobe stays high during every read.
// RULE_02: Read holds selects active, output gate low.
// RULE_03: Address valid no later than select assertion.
// RULE_04: Select and strobe released together keep I/O high-Z.
// RULE_05: Write cycle spans address change to address change.
// RULE_06: Recovery timed from write end before address change.
// RULE_07: Never drive data while memory is in read mode.
// RULE_08: Address valid 40 ns before write end.
// RULE_09: 8192 words of 9 bits, 13-bit address.
// RULE_10: Primary select high puts memory in standby.
// RULE_11: Three-state outputs share a common bus.
// RULE_12: Mode decoded from selects, strobe and output gate.
// RULE_13: Data stored when first write condition ends.
`ifndef SRAM_CTL_PARAMS_SVH
`define SRAM_CTL_PARAMS_SVH

// ****************************************************************
// Widths
// ****************************************************************
`define SRAM_ADDR_W  13
`define SRAM_DATA_W  9
`define SRAM_WORDS   8192
`define CNT_W        4

// ****************************************************************
// Clock period in ps, times in ns (slower speed grade)
// ****************************************************************
`define MCLK_PS      8000
`define T_RC_NS      45
`define T_AA_NS      45
`define T_WC_NS      45
`define T_AW_NS      40
`define T_CW_NS      40
`define T_WP_NS      25
`define T_DW_NS      20
`define T_WR_NS      3
`define T_HZ_NS      25
`define SYNC_STAGES  2

// ****************************************************************
// Cycle counts, least times rounded up
// ****************************************************************
`define NS2CYC(t)    ((((t) * 1000) + `MCLK_PS - 1) / `MCLK_PS)
`define AA_CYC       `NS2CYC(`T_AA_NS)
`define AW_CYC       `NS2CYC(`T_AW_NS)
`define WC_CYC       `NS2CYC(`T_WC_NS)
`define WR_CYC       `NS2CYC(`T_WR_NS)
`define HZ_CYC       `NS2CYC(`T_HZ_NS)

// ****************************************************************
// Pin levels
// ****************************************************************
`define PIN_ON_N     1'h0
`define PIN_OFF_N    1'h1

`endif

/* inc/sram_ctl_pkg.sv */
// Types shared by the SRAM host controller and its input synchroniser.
// Assumes the constants header is on the include path.
`include "sram_ctl_params.svh"

package sram_ctl_pkg;

  // ****************************************************************
  // Sequencer phases
  // ****************************************************************
  typedef enum logic [2:0] {
    PH_IDLE,
    PH_RD_ACCESS,
    PH_WR_SETUP,
    PH_WR_PULSE,
    PH_WR_RECOVER,
    PH_TURNAROUND
  } phase_e;

  typedef logic [`SRAM_ADDR_W-1:0] addr_t;
  typedef logic [`SRAM_DATA_W-1:0] data_t;
  typedef logic [`CNT_W-1:0]       cnt_t;

  // ****************************************************************
  // Pin group driven towards the memory
  // ****************************************************************
  typedef struct packed {
    addr_t addr;
    logic  primary_select_n;
    logic  secondary_select;
    logic  out_gate_n;
    logic  write_strobe_n;
    data_t dq_out;
    logic  dq_oe;
  } pins_s;

  // ****************************************************************
  // Controller state
  // ****************************************************************
  typedef struct packed {
    phase_e phase;
    cnt_t   cnt;
    pins_s  pins;
    logic   ready;
    logic   rvalid;
    data_t  rdata;
  } ctl_s;

  // ****************************************************************
  // Synchroniser state
  // ****************************************************************
  typedef struct packed {
    data_t stage1;
    data_t stage2;
  } sync_s;

endpackage

/* hdl/dq_sync.sv */
// Two-flop synchroniser for the data pins coming back from the memory.
// Assumes the pins change asynchronously to the controller clock.
`timescale 1ns/1ns
`include "sram_ctl_params.svh"

module dq_sync (
  input  wire logic                 clk_i,
  input  wire logic                 nrst_i,
  input  wire sram_ctl_pkg::data_t  d_i,
  output sram_ctl_pkg::data_t       q_o
);

  sram_ctl_pkg::sync_s st_r;
  sram_ctl_pkg::sync_s st_nxt;

  // ****************************************************************
  // Per-bit stages
  // ****************************************************************
  genvar b;
  generate
    for (b = 0; b < `SRAM_DATA_W; b = b + 1) begin : g_bit
      always_comb begin
        st_nxt.stage1[b] = d_i[b];
        st_nxt.stage2[b] = st_r.stage1[b];
      end
    end
  endgenerate

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign q_o = st_r.stage2;

endmodule

/* hdl/sram_host_ctl.sv */
// Host-side controller running read and write cycles on an asynchronous 8192 x 9 SRAM.
// Assumes a single 125 MHz clock; the memory data pins return through a two-flop synchroniser.
`timescale 1ns/1ns
`include "sram_ctl_params.svh"

module sram_host_ctl #(
  parameter int RD_WAIT  = `AA_CYC + `SYNC_STAGES,
  parameter int WR_PULSE = `AW_CYC,
  parameter int WR_RECOV = ((`WC_CYC - 1 - `AW_CYC) > `WR_CYC) ?
                           (`WC_CYC - 1 - `AW_CYC) : `WR_CYC,
  parameter int TURN     = `HZ_CYC
) (
  input  wire logic                 MCLK_I,
  input  wire logic                 NRST_I,
  input  wire logic                 REQ_I,
  input  wire logic                 WRITE_I,
  input  wire sram_ctl_pkg::addr_t  ADDR_I,
  input  wire sram_ctl_pkg::data_t  WDATA_I,
  output logic                      READY_O,
  output logic                      RVALID_O,
  output sram_ctl_pkg::data_t       RDATA_O,
  output sram_ctl_pkg::addr_t       SRAM_ADDR_O,
  output logic                      PRIMARY_SELECT_N_O,
  output logic                      SECONDARY_SELECT_O,
  output logic                      OUT_GATE_N_O,
  output logic                      WRITE_STROBE_N_O,
  input  wire sram_ctl_pkg::data_t  DQ_I,
  output sram_ctl_pkg::data_t       DQ_O,
  output logic                      DQ_OE_O
);

  // ****************************************************************
  // Elaboration checks
  // ****************************************************************
  localparam int CNT_MAX = (1 << `CNT_W) - 1;

  generate
    if (RD_WAIT < `AA_CYC + `SYNC_STAGES || RD_WAIT > CNT_MAX) begin : g_bad_rd
      $error("RD_WAIT out of range");
    end
    if (WR_PULSE < `AW_CYC || WR_PULSE > CNT_MAX) begin : g_bad_wp
      $error("WR_PULSE out of range");
    end
    if (WR_RECOV < `WR_CYC || WR_RECOV > CNT_MAX) begin : g_bad_wr
      $error("WR_RECOV out of range");
    end
    if (TURN < `HZ_CYC || TURN > CNT_MAX) begin : g_bad_turn
      $error("TURN out of range");
    end
    if (1 + WR_PULSE + WR_RECOV < `WC_CYC) begin : g_bad_wc
      $error("write cycle shorter than minimum");
    end
    if (1 + RD_WAIT + TURN < `NS2CYC(`T_RC_NS)) begin : g_bad_rc
      $error("read cycle shorter than minimum");
    end
    if (1 + WR_PULSE < `NS2CYC(`T_CW_NS)) begin : g_bad_cw
      $error("select to end of write too short");
    end
    if (WR_PULSE < `NS2CYC(`T_WP_NS)) begin : g_bad_pw
      $error("write pulse too short");
    end
    if (1 + WR_PULSE < `NS2CYC(`T_DW_NS)) begin : g_bad_dw
      $error("data setup to end of write too short");
    end
    if (`SYNC_STAGES != 2) begin : g_bad_sync
      $error("synchroniser depth is fixed at two");
    end
    if ((1 << `SRAM_ADDR_W) != `SRAM_WORDS) begin : g_bad_words
      $error("address width does not match word count");
    end
  endgenerate

  localparam sram_ctl_pkg::cnt_t RD_CNT   = sram_ctl_pkg::cnt_t'(RD_WAIT);
  localparam sram_ctl_pkg::cnt_t WP_CNT   = sram_ctl_pkg::cnt_t'(WR_PULSE);
  localparam sram_ctl_pkg::cnt_t WR_CNT   = sram_ctl_pkg::cnt_t'(WR_RECOV);
  localparam sram_ctl_pkg::cnt_t TURN_CNT = sram_ctl_pkg::cnt_t'(TURN);
  localparam sram_ctl_pkg::cnt_t CNT_ONE  = sram_ctl_pkg::cnt_t'(1);

  // ****************************************************************
  // Parked pins, memory deselected and bus released
  // ****************************************************************
  localparam sram_ctl_pkg::pins_s PINS_PARKED = '{
    addr:             '0,
    primary_select_n: `PIN_OFF_N, // RULE_10
    secondary_select: 1'h0,
    out_gate_n:       `PIN_OFF_N,
    write_strobe_n:   `PIN_OFF_N,
    dq_out:           '0,
    dq_oe:            1'h0
  };

  // ****************************************************************
  // Returning data synchroniser
  // ****************************************************************
  sram_ctl_pkg::data_t dq_sync_w;

  dq_sync u_dq_sync (
    .clk_i  (MCLK_I),
    .nrst_i (NRST_I),
    .d_i    (DQ_I),
    .q_o    (dq_sync_w)
  );

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  sram_ctl_pkg::ctl_s st_r;
  sram_ctl_pkg::ctl_s st_nxt;

  logic last_w;
  assign last_w = (st_r.cnt == CNT_ONE);

  // ****************************************************************
  // Request acceptance
  // ****************************************************************
  logic take_w;
  assign take_w = REQ_I && st_r.ready;

  always_comb begin
    st_nxt        = st_r;
    st_nxt.rvalid = 1'h0;
    if (st_r.cnt != '0) begin
      st_nxt.cnt = st_r.cnt - CNT_ONE;
    end

    case (st_r.phase)
      sram_ctl_pkg::PH_IDLE: begin
        if (take_w) begin
          st_nxt.ready                 = 1'h0;
          st_nxt.pins.addr             = ADDR_I; // RULE_03
          st_nxt.pins.primary_select_n = `PIN_ON_N; // RULE_02
          st_nxt.pins.secondary_select = 1'h1; // RULE_02
          st_nxt.pins.write_strobe_n   = `PIN_OFF_N; // RULE_01
          if (WRITE_I) begin
            st_nxt.pins.out_gate_n = `PIN_OFF_N; // RULE_07
            st_nxt.pins.dq_out     = WDATA_I;
            st_nxt.pins.dq_oe      = 1'h1;
            st_nxt.phase           = sram_ctl_pkg::PH_WR_SETUP;
          end else begin
            st_nxt.pins.out_gate_n = `PIN_ON_N; // RULE_02
            st_nxt.pins.dq_oe      = 1'h0; // RULE_07
            st_nxt.cnt             = RD_CNT;
            st_nxt.phase           = sram_ctl_pkg::PH_RD_ACCESS;
          end
        end
      end

      sram_ctl_pkg::PH_RD_ACCESS: begin
        if (last_w) begin
          st_nxt.rdata                 = dq_sync_w;
          st_nxt.rvalid                = 1'h1;
          st_nxt.pins.primary_select_n = `PIN_OFF_N; // RULE_10
          st_nxt.pins.secondary_select = 1'h0;
          st_nxt.pins.out_gate_n       = `PIN_OFF_N;
          st_nxt.cnt                   = TURN_CNT; // RULE_07
          st_nxt.phase                 = sram_ctl_pkg::PH_TURNAROUND;
        end
      end

      sram_ctl_pkg::PH_WR_SETUP: begin
        st_nxt.pins.write_strobe_n = `PIN_ON_N; // RULE_12
        st_nxt.cnt                 = WP_CNT; // RULE_08
        st_nxt.phase               = sram_ctl_pkg::PH_WR_PULSE;
      end

      sram_ctl_pkg::PH_WR_PULSE: begin
        if (last_w) begin
          st_nxt.pins.write_strobe_n = `PIN_OFF_N; // RULE_13
          st_nxt.cnt                 = WR_CNT; // RULE_06
          st_nxt.phase               = sram_ctl_pkg::PH_WR_RECOVER;
        end
      end

      sram_ctl_pkg::PH_WR_RECOVER: begin
        if (last_w) begin
          st_nxt.pins.primary_select_n = `PIN_OFF_N; // RULE_10
          st_nxt.pins.secondary_select = 1'h0;
          st_nxt.pins.dq_oe            = 1'h0;
          st_nxt.ready                 = 1'h1; // RULE_05
          st_nxt.phase                 = sram_ctl_pkg::PH_IDLE;
        end
      end

      sram_ctl_pkg::PH_TURNAROUND: begin
        if (last_w) begin
          st_nxt.ready = 1'h1;
          st_nxt.phase = sram_ctl_pkg::PH_IDLE;
        end
      end

      default: begin
        st_nxt.phase = sram_ctl_pkg::PH_IDLE;
        st_nxt.ready = 1'h1;
      end
    endcase
  end

  always_ff @(posedge MCLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      st_r                       <= '0;
      st_r.phase                 <= sram_ctl_pkg::PH_IDLE;
      st_r.ready                 <= 1'h1;
      st_r.pins                  <= PINS_PARKED;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign READY_O            = st_r.ready;
  assign RVALID_O           = st_r.rvalid;
  assign RDATA_O            = st_r.rdata;
  assign SRAM_ADDR_O        = st_r.pins.addr;
  assign PRIMARY_SELECT_N_O = st_r.pins.primary_select_n;
  assign SECONDARY_SELECT_O = st_r.pins.secondary_select;
  assign OUT_GATE_N_O       = st_r.pins.out_gate_n;
  assign WRITE_STROBE_N_O   = st_r.pins.write_strobe_n;
  assign DQ_O               = st_r.pins.dq_out;
  assign DQ_OE_O            = st_r.pins.dq_oe;

endmodule

/* testbench/sram_host_ctl_properties.sv */
// Concurrent checks on the SRAM host controller pins and user handshake.
// Assumes it is bound to sram_host_ctl and sees only its ports.
`timescale 1ns/1ns

module sram_host_ctl_properties #(
  parameter int RD_WAIT = 8,
  parameter int TURN    = 4
) (
  input wire logic                MCLK_I,
  input wire logic                NRST_I,
  input wire logic                REQ_I,
  input wire logic                WRITE_I,
  input wire sram_ctl_pkg::addr_t ADDR_I,
  input wire sram_ctl_pkg::data_t WDATA_I,
  input wire logic                READY_O,
  input wire logic                RVALID_O,
  input wire sram_ctl_pkg::data_t RDATA_O,
  input wire sram_ctl_pkg::addr_t SRAM_ADDR_O,
  input wire logic                PRIMARY_SELECT_N_O,
  input wire logic                SECONDARY_SELECT_O,
  input wire logic                OUT_GATE_N_O,
  input wire logic                WRITE_STROBE_N_O,
  input wire sram_ctl_pkg::data_t DQ_I,
  input wire sram_ctl_pkg::data_t DQ_O,
  input wire logic                DQ_OE_O
);
  // ****************************************************************
  // Pin and handshake relations
  // ****************************************************************
  default clocking cb @(posedge MCLK_I);
  endclocking
  default disable iff (!NRST_I);
  logic take_rd;
  logic take_wr;
  assign take_rd = REQ_I && READY_O && !WRITE_I;
  assign take_wr = REQ_I && READY_O && WRITE_I;

  a_rd_strobe_high: assert property (!OUT_GATE_N_O |-> WRITE_STROBE_N_O)
    else $error("strobe low in read");
  a_no_bus_fight: assert property (DQ_OE_O |-> OUT_GATE_N_O)
    else $error("drive while gate on");
  a_addr_held_sel: assert property (!PRIMARY_SELECT_N_O && $past(!PRIMARY_SELECT_N_O)
    |-> $stable(SRAM_ADDR_O)) else $error("address moved while selected");
  a_recover_addr: assert property ($rose(WRITE_STROBE_N_O) |=> $stable(SRAM_ADDR_O))
    else $error("address moved at write end");
  a_addr_setup_wr: assert property ($rose(WRITE_STROBE_N_O) |->
    $past(!PRIMARY_SELECT_N_O, 5) && $past(SRAM_ADDR_O, 5) == SRAM_ADDR_O)
    else $error("address setup short");
  a_write_cycle_len: assert property ($fell(WRITE_STROBE_N_O) |-> $stable(SRAM_ADDR_O) [*5])
    else $error("write cycle short");
  a_read_seq: assert property (take_rd |=> (!PRIMARY_SELECT_N_O && SECONDARY_SELECT_O
    && !OUT_GATE_N_O && !DQ_OE_O && !RVALID_O) [*8] ##1 (RVALID_O && PRIMARY_SELECT_N_O))
    else $error("read cycle wrong");
  a_write_seq: assert property (take_wr |=> (!PRIMARY_SELECT_N_O && DQ_OE_O
    && WRITE_STROBE_N_O && SRAM_ADDR_O == $past(ADDR_I) && DQ_O == $past(WDATA_I))
    ##1 (!WRITE_STROBE_N_O && DQ_OE_O) [*5] ##1 (WRITE_STROBE_N_O && DQ_OE_O)
    ##1 (PRIMARY_SELECT_N_O && READY_O)) else $error("write cycle wrong");
  a_read_turn: assert property ($rose(RVALID_O) |-> !READY_O ##1
    (!READY_O && !RVALID_O && !DQ_OE_O) [*3] ##1 READY_O) else $error("turnaround wrong");

  c_read: cover property (take_rd);
  c_write: cover property (take_wr);
  c_busy_req: cover property (REQ_I && !READY_O);
endmodule

bind sram_host_ctl sram_host_ctl_properties #(.RD_WAIT(RD_WAIT), .TURN(TURN)) chk (.*);

/* testbench/sram_mem_model.sv */
// Behavioural 8192 x 9 static RAM with common I/O and a settable access time.
// Assumes the bench resolves the shared data pins from the controller's DQ_OE_O alone.
`timescale 1ns/1ns
`include "sram_ctl_params.svh"

module sram_mem_model (
  input  wire sram_ctl_pkg::addr_t addr_i,
  input  wire logic                psel_n_i,
  input  wire logic                ssel_i,
  input  wire logic                oe_n_i,
  input  wire logic                we_n_i,
  input  wire sram_ctl_pkg::data_t d_i,
  output sram_ctl_pkg::data_t      q_o
);
  // ****************************************************************
  // Storage and mode decode
  // ****************************************************************
  sram_ctl_pkg::data_t mem [`SRAM_WORDS];
  sram_ctl_pkg::data_t wd;
  sram_ctl_pkg::addr_t wa;
  int                  acc_ns = 45;
  longint              t_ok;
  wire sel = !psel_n_i && ssel_i;
  wire rd  = sel && we_n_i && !oe_n_i;
  wire wr  = sel && !we_n_i;
  initial q_o = '0;
  always @(addr_i, rd) t_ok = $time + acc_ns;
  // Not driving: pins wander every ns
  always #1 q_o = (rd && $time >= t_ok) ? mem[addr_i] : ~q_o;
  always @(addr_i, d_i, wr) if (wr) begin
    wd = d_i;
    wa = addr_i;
  end
  always @(negedge wr) mem[wa] = wd;
endmodule

/* testbench/async_sram_8kx9_rw_cycles_bench.sv */
// Self-checking bench for the SRAM host controller with a behavioural memory.
// Assumes the checker is bound to the controller.
`timescale 1ns/1ns

module async_sram_8kx9_rw_cycles_bench;
  logic                MCLK_I, NRST_I, REQ_I, WRITE_I, READY_O, RVALID_O;
  logic                PRIMARY_SELECT_N_O, SECONDARY_SELECT_O, OUT_GATE_N_O;
  logic                WRITE_STROBE_N_O, DQ_OE_O;
  sram_ctl_pkg::addr_t ADDR_I, SRAM_ADDR_O;
  sram_ctl_pkg::data_t WDATA_I, RDATA_O, DQ_O, DQ_I, mem_q;
  int                  error_cnt, total_checks;

  sram_host_ctl uut (.*);
  sram_mem_model mem (.addr_i(SRAM_ADDR_O), .psel_n_i(PRIMARY_SELECT_N_O),
    .ssel_i(SECONDARY_SELECT_O), .oe_n_i(OUT_GATE_N_O), .we_n_i(WRITE_STROBE_N_O),
    .d_i(DQ_I), .q_o(mem_q));
  assign DQ_I = DQ_OE_O ? DQ_O : mem_q;

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic check(input string nm, input logic [12:0] seen, input logic [12:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic wait_high(input string nm, input bit on_rvalid);
    int n;
    n = 0;
    do begin
      @(posedge MCLK_I);
      n++;
    end while ((on_rvalid ? RVALID_O : READY_O) !== 1'h1 && n < 40);
    if ((on_rvalid ? RVALID_O : READY_O) !== 1'h1) begin
      check(nm, 13'h0000, 13'h0001);
      report_and_stop();
    end
  endtask

  task automatic acc(input logic w, input sram_ctl_pkg::addr_t a, input sram_ctl_pkg::data_t d);
    REQ_I   <= 1'h1;
    WRITE_I <= w;
    ADDR_I  <= a;
    WDATA_I <= d;
    wait_high("ready", 1'h0);
    REQ_I <= 1'h0;
    @(posedge MCLK_I);
    check("addr", 13'(SRAM_ADDR_O), 13'(a));
    check("ready", 13'(READY_O), 13'h0000);
    check("ssel", 13'(SECONDARY_SELECT_O), 13'h0001);
    if (w) begin
      check("dq_o", 13'(DQ_O), 13'(d));
      check("oe_n", 13'(OUT_GATE_N_O), 13'h0001);
    end else begin
      check("oe_n", 13'(OUT_GATE_N_O), 13'h0000);
      wait_high("rvalid", 1'h1);
      check("rdata", 13'(RDATA_O), 13'(d));
    end
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_idle;
    check("sel_n", 13'(PRIMARY_SELECT_N_O), 13'h0001);
    check("dq_oe", 13'(DQ_OE_O), 13'h0000);
    check("we_n", 13'(WRITE_STROBE_N_O), 13'h0001);
    check("ssel", 13'(SECONDARY_SELECT_O), 13'h0000);
    check("oe_n", 13'(OUT_GATE_N_O), 13'h0001);
    check("ready", 13'(READY_O), 13'h0001);
    check("rvalid", 13'(RVALID_O), 13'h0000);
  endtask

  task automatic t_words;
    sram_ctl_pkg::addr_t a [3] = '{13'h0000, 13'h1FFF, 13'h0AAA};
    sram_ctl_pkg::data_t d [3] = '{9'h1FF, 9'h000, 9'h155};
    foreach (a[i]) acc(1'h1, a[i], d[i]);
    foreach (a[i]) acc(1'h0, a[i], d[i]);
  endtask

  task automatic t_refused;
    acc(1'h1, 13'h0006, 9'h0F0);
    REQ_I   <= 1'h1;
    ADDR_I  <= 13'h0006;
    WDATA_I <= 9'h10F;
    repeat (3) @(posedge MCLK_I);
    REQ_I <= 1'h0;
    @(posedge MCLK_I);
    acc(1'h0, 13'h0006, 9'h0F0);
  endtask

  task automatic t_fast;
    mem.acc_ns = 5;
    for (int i = 0; i < 4; i++) begin
      acc(1'h1, 13'h1000 + 13'(i), 9'(9'h0C3 << i));
      acc(1'h0, 13'h1000 + 13'(i), 9'(9'h0C3 << i));
    end
  endtask

  initial begin
    MCLK_I = 1'h0;
    forever #4 MCLK_I = ~MCLK_I;
  end

  initial begin
    NRST_I       = 1'h0;
    REQ_I        = 1'h0;
    WRITE_I      = 1'h0;
    ADDR_I       = '0;
    WDATA_I      = '0;
    error_cnt    = 0;
    total_checks = 0;
    repeat (8) @(posedge MCLK_I);
    NRST_I <= 1'h1;
    @(posedge MCLK_I);
    t_idle();
    t_words();
    t_refused();
    t_fast();
    report_and_stop();
  end
endmodule
